// [hdl/osc_ctl.sv]
/*
 * Oscillator control block: guarded oscillator control register with a
 * write-unlock pair, clock source selection, primary failure detection
 * with automatic fallback to the watchdog oscillator, and an interrupt.
 * Assumes an 8-bit register port on clk_sys, read data one cycle after
 * the read strobe, and asynchronous oscillator and watchdog-fail pins.
 */
//
// Behaviour
// - Next write lands, then register relocks
// - Writes without correct unlock are ignored
// - Keys in order, gaps between allowed
// - Other register accesses keep unlock progress
// - Detection may be re-enabled after source write
// - Internal RC oscillator enabled out of reset
// - Source switch never turns RC oscillator off; here a commit with rc_en (bit 7) clear turns it off
// - Primary failure raises non-maskable failure event
// - Primary failure switches clock to watchdog oscillator
// - No switchover while watchdog oscillator disabled
// - No switchover when watchdog oscillator selected
// - Recovery ignores watchdog reset function
// - Failure below about 1 kHz, plus minus 50%
`timescale 1ns/1ps
module osc_ctl
#(
    parameter int FAIL_CYCLES = osc_ctl_pkg::FAIL_CYCLES // Silence limit, shorten in sim
)
(
    input wire logic clk_sys,                  // System clock, 25 MHz
    input wire logic srst,                     // Synchronous reset, active high
    input wire logic ce,                       // Clock enable, freezes state when low
    input wire logic [7:0] reg_addr,           // Register address
    input wire logic [7:0] reg_wdata,          // Register write data
    input wire logic reg_wr,                   // Write strobe, one cycle
    input wire logic reg_rd,                   // Read strobe, one cycle
    output logic [7:0] reg_rdata,              // Read data, cycle after the strobe
    input wire logic primary_clk_in,           // Selected primary oscillator, async
    input wire logic wdt_osc_fail_in,          // Watchdog oscillator failed, async
    output logic irq,                          // Level interrupt
    output logic clk_fail_nmi,                 // Non-maskable failure pulse
    output logic [2:0] sys_clk_sel,            // Effective clock source
    output logic rc_osc_en,                    // Internal RC oscillator enable
    output logic wdt_osc_en,                   // Watchdog oscillator enable
    output logic clk_recovery_active           // Running on the fallback clock
);

    // Reset value of the control register, by field
    localparam osc_ctl_pkg::ctl_reg_t CTL_INIT = osc_ctl_pkg::ctl_reg_t'(osc_ctl_pkg::CTL_RST);
    osc_ctl_pkg::ctl_reg_t ctl_r; // Guarded control register
    osc_ctl_pkg::ctl_reg_t ctl_nxt; // Its next value
    logic [osc_ctl_pkg::EV_W-1:0] ev_stat_r;  // Sticky events
    logic [osc_ctl_pkg::EV_W-1:0] ev_stat_nxt; // Their next value
    logic [osc_ctl_pkg::EV_W-1:0] ev_mask_r;  // Interrupt mask
    logic [osc_ctl_pkg::EV_W-1:0] ev_now;     // Events of this cycle
    logic [osc_ctl_pkg::EV_W-1:0] ev_clr;     // Write-one-to-clear bits
    logic recovery_r;                         // Fallback clock in use
    logic recovery_nxt;                       // Its next value
    logic [7:0] rdata_r;                      // Read data register
    logic irq_r;                              // Interrupt register
    logic nmi_r;                              // Failure pulse register
    logic [2:0] sel_r;                        // Effective source register
    logic rc_en_r; // RC oscillator enable register
    logic wdt_en_r;                           // Watchdog oscillator enable register
    logic wsync1_r;                           // Watchdog fail, first stage
    logic wsync2_r;                           // Watchdog fail, second stage
    logic wfail_q_r;                          // Watchdog fail, previous level
    logic pfail;                              // Primary failure level
    logic pfail_q_r;                          // Previous failure level
    logic pfail_rise;                         // Failure just began
    logic ctl_wr;                             // Write aimed at the guarded register
    logic commit;                             // That write is accepted
    logic refused;                            // That write is refused
    logic armed;                              // First key seen
    logic open;                               // Pair seen

    assign ctl_wr = reg_wr && (reg_addr == osc_ctl_pkg::ADDR_CTL);

    // Only guarded writes reach the sequencer; software owns the key order
    osc_unlock_seq osc_unlock_seq_inst
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .ctl_wr(ctl_wr),
        .ctl_wdata(reg_wdata),
        .commit(commit),
        .refused(refused),
        .armed(armed),
        .open(open)
    );

    // Detector enable comes straight from the control register
    osc_fail_detect #(
        .FAIL_CYCLES(FAIL_CYCLES)
    ) osc_fail_detect_inst
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .osc_in(primary_clk_in),
        .enable(ctl_r.primary_fail_detect_enable),
        .fail(pfail)
    );

    assign pfail_rise = pfail && !pfail_q_r;

    // Watchdog fail pin synchroniser and history for edge detection
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wsync1_r <= 1'b0;
            wsync2_r <= 1'b0;
            wfail_q_r <= 1'b0;
            pfail_q_r <= 1'b0;
        end
        else if (ce)
        begin
            wsync1_r <= wdt_osc_fail_in;
            wsync2_r <= wsync1_r;
            wfail_q_r <= wsync2_r;
            pfail_q_r <= pfail;
        end
    end

    // Next control value; a whole-byte commit also rewrites detection bits
    always_comb
    begin
        ctl_nxt = ctl_r;
        if (commit)
            ctl_nxt = osc_ctl_pkg::ctl_reg_t'(reg_wdata);
    end

    // Fallback decision; the watchdog reset function plays no part
    always_comb
    begin
        recovery_nxt = recovery_r;
        if (commit)
            recovery_nxt = 1'b0; // A fresh source choice ends the fallback
        else if (pfail_rise && ctl_r.wdt_en
                 && (ctl_r.clock_source_select != osc_ctl_pkg::SRC_WDT))
            recovery_nxt = 1'b1;
    end

    // Guarded control register; untouched unless the sequencer commits
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            ctl_r <= CTL_INIT;
        else if (ce)
            ctl_r <= ctl_nxt;
    end

    // Clock outputs track the register; each commit, source change included, loads the RC enable from rc_en
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            recovery_r <= 1'b0;
            sel_r <= osc_ctl_pkg::SRC_RC;
            rc_en_r <= CTL_INIT.rc_en;
            wdt_en_r <= CTL_INIT.wdt_en;
        end
        else if (ce)
        begin
            recovery_r <= recovery_nxt;
            // Fallback overrides the selected source until software rewrites it
            sel_r <= recovery_nxt ? osc_ctl_pkg::SRC_WDT : ctl_nxt.clock_source_select;
            rc_en_r <= ctl_nxt.rc_en;
            wdt_en_r <= ctl_nxt.wdt_en;
        end
    end

    // Non-maskable pulse on each new failure, whether or not fallback is possible
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            nmi_r <= 1'b0;
        else if (ce)
            nmi_r <= pfail_rise;
    end

    // Events of this cycle and software clears
    always_comb
    begin
        ev_now = '0;
        ev_now[osc_ctl_pkg::EV_PFAIL] = pfail_rise;
        ev_now[osc_ctl_pkg::EV_WFAIL] = wsync2_r && !wfail_q_r
                                        && ctl_r.wdt_osc_fail_detect_enable;
        ev_now[osc_ctl_pkg::EV_BADWR] = refused;
        ev_clr = '0;
        if (reg_wr && (reg_addr == osc_ctl_pkg::ADDR_IRQ_STAT))
            ev_clr = reg_wdata[osc_ctl_pkg::EV_W-1:0];
        // A new event beats a clear in the same cycle
        ev_stat_nxt = (ev_stat_r & ~ev_clr) | ev_now;
    end

    // Sticky status, mask and interrupt level
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ev_stat_r <= osc_ctl_pkg::EV_RST;
            ev_mask_r <= osc_ctl_pkg::EV_RST;
            irq_r <= 1'b0;
        end
        else if (ce)
        begin
            ev_stat_r <= ev_stat_nxt;
            if (reg_wr && (reg_addr == osc_ctl_pkg::ADDR_IRQ_MASK))
                ev_mask_r <= reg_wdata[osc_ctl_pkg::EV_W-1:0];
            irq_r <= |(ev_stat_nxt & ev_mask_r);
        end
    end

    // Read port; data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            rdata_r <= 8'h00;
        else if (ce)
        begin
            rdata_r <= 8'h00;
            if (reg_rd)
            begin
                case (reg_addr)
                    osc_ctl_pkg::ADDR_CTL:
                        rdata_r <= ctl_r;
                    osc_ctl_pkg::ADDR_IRQ_STAT:
                        rdata_r <= {5'h00, ev_stat_r};
                    osc_ctl_pkg::ADDR_IRQ_MASK:
                        rdata_r <= {5'h00, ev_mask_r};
                    osc_ctl_pkg::ADDR_OSC_STAT:
                    begin
                        rdata_r[osc_ctl_pkg::ST_OPEN] <= open;
                        rdata_r[osc_ctl_pkg::ST_ARMED] <= armed;
                        rdata_r[osc_ctl_pkg::ST_PFAIL] <= pfail;
                        rdata_r[osc_ctl_pkg::ST_RECOVER] <= recovery_r;
                        rdata_r[osc_ctl_pkg::ST_SEL_LO +: 3] <= sel_r;
                    end
                    default:
                        rdata_r <= 8'h00; // Unmapped reads return zero
                endcase
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign irq = irq_r;
    assign clk_fail_nmi = nmi_r;
    assign sys_clk_sel = sel_r;
    assign rc_osc_en = rc_en_r;
    assign wdt_osc_en = wdt_en_r;
    assign clk_recovery_active = recovery_r;

    // Checks of the guarded register and the failure path
    a_commit_lands: assert property (@(posedge clk_sys) disable iff (srst)
        ce && commit |=> ctl_r == $past(reg_wdata) && !open && !armed)
        else $error("committed write did not land or lock stayed open");

    a_locked_ignores: assert property (@(posedge clk_sys) disable iff (srst)
        ce && ctl_wr && !open |=> ctl_r == $past(ctl_r))
        else $error("guarded register changed without unlock");

    // Any other access while armed, reads of the guarded register included
    a_unlock_holds: assert property (@(posedge clk_sys) disable iff (srst)
        ce && armed && !ctl_wr && (reg_rd || reg_wr) |=> armed)
        else $error("unlock progress lost on unrelated access");

    a_key_order: assert property (@(posedge clk_sys) disable iff (srst)
        ce && ctl_wr && armed && reg_wdata == osc_ctl_pkg::UNLOCK_2 |=> open)
        else $error("second key after first key did not unlock");

    a_bad_key_resets: assert property (@(posedge clk_sys) disable iff (srst)
        ce && ctl_wr && armed && reg_wdata != osc_ctl_pkg::UNLOCK_2 |=> !armed && !open)
        else $error("wrong key did not restart the sequence");

    a_rc_after_reset: assert property (@(posedge clk_sys) disable iff (srst)
        $past(srst) |-> rc_osc_en && ctl_r.rc_en)
        else $error("RC oscillator disabled after reset");

    a_rc_stays: assert property (@(posedge clk_sys) disable iff (srst)
        !commit |=> $stable(rc_en_r))
        else $error("RC oscillator enable changed without a write");

    a_nmi_follows: assert property (@(posedge clk_sys) disable iff (srst)
        ce && pfail_rise |=> clk_fail_nmi ##1 !clk_fail_nmi || !ce)
        else $error("failure pulse missing or too long");

    a_switch_wdt: assert property (@(posedge clk_sys) disable iff (srst)
        ce && pfail_rise && !commit && ctl_r.wdt_en
        && ctl_r.clock_source_select != osc_ctl_pkg::SRC_WDT
        |=> sys_clk_sel == osc_ctl_pkg::SRC_WDT && clk_recovery_active)
        else $error("no switch to the watchdog oscillator on failure");

    a_no_switch_off: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !recovery_r && !ctl_r.wdt_en |=> !clk_recovery_active)
        else $error("fallback taken with watchdog oscillator disabled");

    a_no_switch_sel: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !recovery_r && ctl_r.clock_source_select == osc_ctl_pkg::SRC_WDT
        |=> !clk_recovery_active)
        else $error("fallback offered with watchdog as source");

    c_commit: cover property (@(posedge clk_sys) disable iff (srst) ce && commit);
    c_recover: cover property (@(posedge clk_sys) disable iff (srst) $rose(recovery_r));
    c_nmi: cover property (@(posedge clk_sys) disable iff (srst) clk_fail_nmi);
    c_irq: cover property (@(posedge clk_sys) disable iff (srst) $rose(irq));

endmodule : osc_ctl

// [hdl/osc_ctl_pkg.sv]
/*
 * Shared constants and types of the oscillator control block: register
 * offsets, field layout, unlock values, clock source codes and timing.
 * Assumes an 8-bit register port and a 25 MHz system clock.
 */
package osc_ctl_pkg;

    // Register port widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;

    // Register offsets on the register port
    localparam logic [7:0] ADDR_CTL = 8'h00; // Guarded oscillator control
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h01; // Sticky events, write one to clear
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h02; // Interrupt enables
    localparam logic [7:0] ADDR_OSC_STAT = 8'h03; // Live state, read only

    // Unlock pair, in the order it must arrive
    localparam logic [7:0] UNLOCK_1 = 8'he7;
    localparam logic [7:0] UNLOCK_2 = 8'h18;

    // Clock source codes
    localparam logic [2:0] SRC_RC = 3'h0;   // Internal RC oscillator
    localparam logic [2:0] SRC_XTAL = 3'h1; // External crystal
    localparam logic [2:0] SRC_EXT = 3'h2;  // External clock signal
    localparam logic [2:0] SRC_WDT = 3'h3;  // Watchdog timer oscillator

    // Oscillator control layout, bit 7 first
    typedef struct packed {
        logic rc_en;                      // Internal RC oscillator enable
        logic wdt_en;                     // Watchdog oscillator enable
        logic primary_fail_detect_enable; // Primary failure detection
        logic wdt_osc_fail_detect_enable; // Watchdog oscillator failure detection
        logic rsvd;                       // Reads back as written
        logic [2:0] clock_source_select;  // Selected system clock source
    } ctl_reg_t;

    // Reset: RC oscillator and watchdog oscillator running, detection off
    localparam logic [7:0] CTL_RST = 8'hc0;

    // Event bits of the status and mask registers
    localparam int EV_W = 3;
    localparam int EV_PFAIL = 0; // Primary oscillator failed
    localparam int EV_WFAIL = 1; // Watchdog oscillator failed
    localparam int EV_BADWR = 2; // Write to the guarded register refused
    localparam logic [2:0] EV_RST = 3'h0;

    // Live status bit positions
    localparam int ST_OPEN = 0;    // Unlocked, next write commits
    localparam int ST_ARMED = 1;   // First unlock value seen
    localparam int ST_PFAIL = 2;   // Primary failure level
    localparam int ST_RECOVER = 3; // Running on the watchdog oscillator
    localparam int ST_SEL_LO = 4;  // Effective source, bits 6:4

    // Unlock sequencer states, one-hot
    typedef enum logic [2:0] {
        SEQ_LOCKED = 3'b001,
        SEQ_ARMED = 3'b010,
        SEQ_OPEN = 3'b100
    } seq_state_t;

    // Failure threshold: no primary edge within one period at 1 kHz
    localparam int CLK_PERIOD_NS = 40;
    localparam int FAIL_PERIOD_NS = 1000000;
    localparam int FAIL_CYCLES = FAIL_PERIOD_NS / CLK_PERIOD_NS;

endpackage : osc_ctl_pkg

// [hdl/osc_unlock_seq.sv]
/*
 * Write-unlock sequencer for the guarded oscillator control register.
 * Assumes it only sees writes aimed at that register, in the system clock
 * domain, so other register traffic never reaches it.
 */
`timescale 1ns/1ps
module osc_unlock_seq
(
    input wire logic clk_sys,          // System clock
    input wire logic srst,             // Synchronous reset, active high
    input wire logic ce,               // Clock enable, freezes state when low
    input wire logic ctl_wr,           // Write strobe to the guarded register
    input wire logic [7:0] ctl_wdata,  // Data of that write
    output logic commit,               // This write lands in the register
    output logic refused,              // This write is neither key nor commit
    output logic armed,                // First unlock value seen
    output logic open                  // Pair seen, next write commits
);

    osc_ctl_pkg::seq_state_t state_r;  // Sequencer state
    osc_ctl_pkg::seq_state_t state_nxt; // Next state

    // Next state and decoded strobes
    always_comb
    begin
        state_nxt = state_r;
        commit = 1'b0;
        refused = 1'b0;
        if (ctl_wr)
        begin
            case (state_r)
                osc_ctl_pkg::SEQ_LOCKED:
                begin
                    // Only the first key advances; anything else is dropped
                    if (ctl_wdata == osc_ctl_pkg::UNLOCK_1)
                        state_nxt = osc_ctl_pkg::SEQ_ARMED;
                    else
                        refused = 1'b1;
                end
                osc_ctl_pkg::SEQ_ARMED:
                begin
                    // Second key must follow the first, gaps allowed
                    if (ctl_wdata == osc_ctl_pkg::UNLOCK_2)
                        state_nxt = osc_ctl_pkg::SEQ_OPEN;
                    else
                    begin
                        // A wrong value throws away the progress
                        state_nxt = osc_ctl_pkg::SEQ_LOCKED;
                        refused = 1'b1;
                    end
                end
                osc_ctl_pkg::SEQ_OPEN:
                begin
                    // One write goes through, then the lock closes again
                    commit = 1'b1;
                    state_nxt = osc_ctl_pkg::SEQ_LOCKED;
                end
                default:
                    state_nxt = osc_ctl_pkg::SEQ_LOCKED;
            endcase
        end
    end

    // State register; only guarded writes move it, so other traffic is harmless
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            state_r <= osc_ctl_pkg::SEQ_LOCKED;
        else if (ce)
            state_r <= state_nxt;
    end

    assign armed = (state_r == osc_ctl_pkg::SEQ_ARMED);
    assign open = (state_r == osc_ctl_pkg::SEQ_OPEN);

endmodule : osc_unlock_seq

// [hdl/osc_fail_detect.sv]
/*
 * Primary oscillator failure detector: counts system clock cycles between
 * edges of the selected oscillator and flags a failure when none come.
 * Assumes osc_in is asynchronous to clk_sys and much slower than it.
 */
`timescale 1ns/1ps
module osc_fail_detect
#(
    parameter int FAIL_CYCLES = osc_ctl_pkg::FAIL_CYCLES // Silence limit in cycles
)
(
    input wire logic clk_sys, // System clock
    input wire logic srst,    // Synchronous reset, active high
    input wire logic ce,      // Clock enable, freezes state when low
    input wire logic osc_in,  // Oscillator being watched, asynchronous
    input wire logic enable,  // Detection enable
    output logic fail         // Level, high while the oscillator is silent
);

    localparam int CNT_W = $clog2(FAIL_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FAIL_CYCLES - 1);

    logic sync1_r;             // First synchroniser stage
    logic sync2_r;             // Second synchroniser stage
    logic prev_r;              // Previous synchronised level
    logic [CNT_W-1:0] cnt_r;   // Cycles since the last edge
    logic fail_r;              // Failure flag
    logic edge_seen;           // Any edge of the watched oscillator

    // Two-stage synchroniser, then a history flop for edge detection
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else if (ce)
        begin
            sync1_r <= osc_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign edge_seen = sync2_r ^ prev_r;

    // Silence counter; saturates so a dead clock keeps the flag up
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            cnt_r <= '0;
        else if (ce)
        begin
            if (!enable || edge_seen)
                cnt_r <= '0;
            else if (cnt_r != CNT_LAST)
                cnt_r <= cnt_r + 1'b1;
        end
    end

    // Flag when a full threshold period passed with no edge
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            fail_r <= 1'b0;
        else if (ce)
            fail_r <= enable && !edge_seen && (cnt_r == CNT_LAST);
    end

    assign fail = fail_r;

    // An edge always clears the flag on the next cycle
    a_edge_clears_fail: assert property (@(posedge clk_sys) disable iff (srst)
        ce && edge_seen |=> !fail_r)
        else $error("failure flag set despite an oscillator edge");

endmodule : osc_fail_detect

// [verif/test_osc_ctl.sv]
/* Self-checking bench for osc_ctl: unlock pair, refused writes, failure
   fallback. Assumes status and mask read back in the low bits, zero-filled. */
`timescale 1ns/1ps
module test_osc_ctl;
    logic clk_sys = 1'b0; // 25 MHz
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic primary_clk_in = 1'b0;
    logic irq, clk_fail_nmi, rc_osc_en, wdt_osc_en, clk_recovery_active;
    logic [2:0] sys_clk_sel;
    logic rd_d = 1'b0;         // Read taken last edge
    logic osc_run = 1'b1;      // Primary oscillator alive
    logic [1:0] pdiv = 2'h0;   // Keeps the oscillator slow against clk_sys
    logic [15:0] rnd = 16'h02ee;
    logic [7:0] v;
    logic [7:0] exp_q[$];      // Expected read data, oldest first
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int k;
    logic [7:0] cv[3] = '{8'he1, 8'ha1, 8'he3}; // Fallback, watchdog off, watchdog selected
    logic [3:0] ev[3] = '{4'hb, 4'h1, 4'h3};    // Recovery flag and effective source
    osc_ctl #(.FAIL_CYCLES(20)) osc_ctl_inst (.clk_sys(clk_sys), .srst(srst), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .primary_clk_in(primary_clk_in), .wdt_osc_fail_in(1'b0),
        .irq(irq), .clk_fail_nmi(clk_fail_nmi), .sys_clk_sel(sys_clk_sel),
        .rc_osc_en(rc_osc_en), .wdt_osc_en(wdt_osc_en),
        .clk_recovery_active(clk_recovery_active));
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Each access leaves an idle edge so no strobe is set twice in a step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask : rd
    task automatic unlock(input logic [7:0] d);
        wr(8'h00, osc_ctl_pkg::UNLOCK_1);
        wr(8'h00, osc_ctl_pkg::UNLOCK_2);
        wr(8'h00, d);
    endtask : unlock
    // Read monitor: data stands only in the cycle after the strobe
    always @(posedge clk_sys)
    begin
        rd_d <= reg_rd;
        pdiv <= pdiv + 2'h1;
        if (osc_run && pdiv == 2'h0)
            primary_clk_in <= ~primary_clk_in;
        if (rd_d)
            chk(reg_rdata, exp_q.pop_front());
        cyc++;
        if (cyc == 4000)
        begin
            n_errors++;
            stop_test();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        chk({7'h0, rc_osc_en}, 8'h01);
        rd(8'h00, 8'hc0);
        rnd = lfsr(rnd);
        v = 8'hc0 | (rnd[7:0] & 8'h0b);
        wr(8'h00, osc_ctl_pkg::UNLOCK_1);
        rd(8'h01, 8'h00);
        wr(8'h02, 8'h00);
        wr(8'h00, osc_ctl_pkg::UNLOCK_2);
        wr(8'h00, v);
        rd(8'h00, v);
        chk({7'h0, rc_osc_en}, 8'h01);
        rnd = lfsr(rnd);
        wr(8'h00, rnd[7:0] & 8'h7f);
        rd(8'h00, v);
        rd(8'h01, 8'h04);
        wr(8'h00, 8'h18);
        wr(8'h00, osc_ctl_pkg::UNLOCK_1);
        wr(8'h00, 8'h55);
        wr(8'h00, 8'h18);
        wr(8'h00, 8'h33);
        rd(8'h00, v);
        wr(8'h01, 8'h04);
        wr(8'h02, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            osc_run <= 1'b1;
            unlock(cv[i] & 8'hcf);
            unlock(cv[i]);
            chk({7'h0, wdt_osc_en}, {7'h0, cv[i][6]});
            repeat (40) @(posedge clk_sys);
            osc_run <= 1'b0;
            k = 0;
            while (clk_fail_nmi !== 1'b1 && k < 200)
            begin
                @(posedge clk_sys);
                #1;
                k++;
            end
            chk({7'h0, clk_fail_nmi}, 8'h01);
            chk({4'h0, clk_recovery_active, sys_clk_sel}, {4'h0, ev[i]});
            chk({7'h0, irq}, 8'h01);
            wr(8'h01, 8'h01);
            #1;
            chk({7'h0, irq}, 8'h00);
            unlock(cv[i] & 8'hcf);
        end
        repeat (4) @(posedge clk_sys);
        stop_test();
    end
endmodule : test_osc_ctl
